// *** logic/acs_clkdiv.sv ***
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_clkdiv #(
  parameter int HALF_DIV = `ACS_HALF_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic half_tick,
  output logic conv_clk
);
  localparam int CW = $clog2(HALF_DIV + 1);
  logic [CW-1:0] cnt_q;
  logic clk_q;

  // one tick per half converter period, so 2.5-clock delays stay exact
  assign half_tick = (cnt_q == CW'(HALF_DIV - 1));
  assign conv_clk = clk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= half_tick ? '0 : cnt_q + CW'(1);
      clk_q <= half_tick ? ~clk_q : clk_q;
    end
  end
endmodule : acs_clkdiv

// *** logic/acs_conv_if.sv ***
`timescale 1ns/1ps
interface acs_conv_if;
  logic half_tick;
  logic blk_rst;
  logic capture;
  logic dual;
  logic [11:0] smp_a;
  logic [11:0] smp_b;
  logic res_a_wr;
  logic res_b_wr;
  logic [11:0] res_a;
  logic [11:0] res_b;
  modport seq (output half_tick, blk_rst, capture, dual, smp_a, smp_b,
               input res_a_wr, res_b_wr, res_a, res_b);
  modport pipe (input half_tick, blk_rst, capture, dual, smp_a, smp_b,
                output res_a_wr, res_b_wr, res_a, res_b);
endinterface : acs_conv_if

// *** logic/acs_params.svh ***
// =====================================================================
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// =====================================================================
// register map (byte offsets)
`define ACS_ADDR_W 8
`define ACS_OFF_CTRL1 8'h00
`define ACS_OFF_CTRL3 8'h04
`define ACS_OFF_CHSEL 8'h08
`define ACS_OFF_TRIG 8'h0c
`define ACS_OFF_STAT 8'h10
`define ACS_OFF_MASK 8'h14
`define ACS_OFF_RESA 8'h18
`define ACS_OFF_RESB 8'h1c

// =====================================================================
// fields
`define ACS_NUM_LSB 0
`define ACS_NUM_MSB 3
`define ACS_ACQPS_LSB 8
`define ACS_ACQPS_MSB 11
`define ACS_SRST_BIT 14
`define ACS_DUAL_SAMPLE_SELECT_BIT 0
`define ACS_PWD_BIT 5
`define ACS_BGR_LSB 6
`define ACS_BGR_MSB 7
`define ACS_CH_MSB 3
`define ACS_PAIR_MSB 2
`define ACS_SWTRIG_BIT 0
`define ACS_ST_RESA 0
`define ACS_ST_RESB 1
`define ACS_ST_DONE 2
`define ACS_ST_W 3

// =====================================================================
// timing
`define ACS_SYS_CLK_KHZ 250000
`define ACS_CONV_CLK_KHZ 12500
`define ACS_HALF_DIV (`ACS_SYS_CLK_KHZ / (2 * `ACS_CONV_CLK_KHZ))
`define ACS_CNT_W 6
`define ACS_TRIG_DLY_HALF 6'h05
`define ACS_GAP_SEQ_HALF 6'h02
`define ACS_GAP_SIM_HALF 6'h04
`define ACS_LAT_A_HALF 8
`define ACS_LAT_B_HALF 10
`define ACS_FLAG_DLY 3
`define ACS_DATA_W 12

`endif

// *** logic/acs_pipe.sv ***
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_pipe #(
  parameter int LAT_A = `ACS_LAT_A_HALF,
  parameter int DEPTH = `ACS_LAT_B_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  acs_conv_if.pipe cv
);
  acs_pkg::acs_entry_t st_q [DEPTH];
  acs_pkg::acs_entry_t in_w [DEPTH];
  acs_pkg::acs_entry_t ent_in;
  logic a_wr_q, b_wr_q;
  logic [11:0] a_q, b_q;
  logic a_due, b_due;

  assign ent_in = '{v: cv.capture, dual: cv.dual, a: cv.smp_a, b: cv.smp_b};

  // =====================================================================
  // latency line, one stage per half converter clock; overlapping samples ride it
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_st
    if (g == 0) begin : g_first
      assign in_w[g] = ent_in;
    end else begin : g_next
      assign in_w[g] = st_q[g-1];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_q[g] <= '0;
      else if (cv.blk_rst) st_q[g] <= '0;
      else if (cv.half_tick) st_q[g] <= in_w[g];
    end
  end

  assign a_due = cv.half_tick && st_q[LAT_A-1].v;
  assign b_due = cv.half_tick && st_q[DEPTH-1].v && st_q[DEPTH-1].dual;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_wr_q <= 1'b0;
      b_wr_q <= 1'b0;
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_wr_q <= a_due && !cv.blk_rst;
      b_wr_q <= b_due && !cv.blk_rst;
      a_q <= a_due ? st_q[LAT_A-1].a : a_q;
      b_q <= b_due ? st_q[DEPTH-1].b : b_q;
    end
  end

  assign cv.res_a_wr = a_wr_q;
  assign cv.res_b_wr = b_wr_q;
  assign cv.res_a = a_q;
  assign cv.res_b = b_q;
endmodule : acs_pipe

// *** logic/acs_pkg.sv ***
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'h0,
    ACS_DELAY = 2'h1,
    ACS_SAMPLE = 2'h3,
    ACS_GAP = 2'h2
  } acs_state_t;

  typedef struct packed {
    logic v;
    logic dual;
    logic [11:0] a;
    logic [11:0] b;
  } acs_entry_t;
endpackage : acs_pkg

// *** logic/acs_top.sv ***
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_top #(
  parameter int HALF_DIV = `ACS_HALF_DIV,
  parameter int FLAG_DLY = `ACS_FLAG_DLY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ACS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_module_trigger,
  input wire logic external_start_pin,
  input wire logic [11:0] ain_a,
  input wire logic [11:0] ain_b,
  output logic converter_clock,
  output logic sh_pulse,
  output logic [3:0] sh_chan_a,
  output logic [3:0] sh_chan_b,
  output logic dual_sample_select,
  output logic [1:0] bandgap_ref_power_bits,
  output logic core_power_up_bit,
  output logic irq
);
  acs_conv_if cv ();

  // =====================================================================
  // register state
  logic [3:0] acqps_q;
  logic [3:0] num_q;
  logic dual_sample_select_q;
  logic pwd_q;
  logic [1:0] bgr_q;
  logic [3:0] chsel_q;
  logic [`ACS_ST_W-1:0] stat_q, stat_d;
  logic [`ACS_ST_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic srst_q;

  // =====================================================================
  // bus decode
  logic wr_acc, rd_setup;
  logic hit_ctrl1, hit_ctrl3, hit_chsel, hit_trig, hit_stat, hit_mask, hit_resa, hit_resb;
  logic mapped;
  logic [31:0] rd_mux;

  assign hit_ctrl1 = (paddr == `ACS_OFF_CTRL1);
  assign hit_ctrl3 = (paddr == `ACS_OFF_CTRL3);
  assign hit_chsel = (paddr == `ACS_OFF_CHSEL);
  assign hit_trig = (paddr == `ACS_OFF_TRIG);
  assign hit_stat = (paddr == `ACS_OFF_STAT);
  assign hit_mask = (paddr == `ACS_OFF_MASK);
  assign hit_resa = (paddr == `ACS_OFF_RESA);
  assign hit_resb = (paddr == `ACS_OFF_RESB);
  assign mapped = hit_ctrl1 | hit_ctrl3 | hit_chsel | hit_trig | hit_stat | hit_mask | hit_resa | hit_resb;
  // zero wait states; an unmapped access ends with an error and changes nothing
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = prdata_q;

  assign rd_mux = hit_ctrl1 ? {20'h0, acqps_q, 4'h0, num_q} :
                  hit_ctrl3 ? {24'h0, bgr_q, pwd_q, 4'h0, dual_sample_select_q} :
                  hit_chsel ? {28'h0, chsel_q} :
                  hit_stat ? {29'h0, stat_q} :
                  hit_mask ? {29'h0, mask_q} :
                  hit_resa ? {20'h0, cv.res_a} :
                  hit_resb ? {20'h0, cv.res_b} : 32'h0;

  // =====================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acqps_q <= 4'h0;
      num_q <= 4'h0;
      dual_sample_select_q <= 1'b0;
      pwd_q <= 1'b0;
      bgr_q <= 2'h0;
      chsel_q <= 4'h0;
      mask_q <= '0;
      srst_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      srst_q <= wr_acc && hit_ctrl1 && pwdata[`ACS_SRST_BIT];
      prdata_q <= rd_setup ? rd_mux : prdata_q;
      if (wr_acc && hit_ctrl1) begin
        acqps_q <= pwdata[`ACS_ACQPS_MSB:`ACS_ACQPS_LSB];
        num_q <= pwdata[`ACS_NUM_MSB:`ACS_NUM_LSB];
      end
      if (wr_acc && hit_ctrl3) begin
        bgr_q <= pwdata[`ACS_BGR_MSB:`ACS_BGR_LSB];
        pwd_q <= pwdata[`ACS_PWD_BIT];
        dual_sample_select_q <= pwdata[`ACS_DUAL_SAMPLE_SELECT_BIT];
      end
      if (wr_acc && hit_chsel) chsel_q <= pwdata[`ACS_CH_MSB:0];
      if (wr_acc && hit_mask) mask_q <= pwdata[`ACS_ST_W-1:0];
    end
  end

  assign bandgap_ref_power_bits = bgr_q;
  assign core_power_up_bit = pwd_q;
  assign dual_sample_select = dual_sample_select_q;

  // =====================================================================
  // converter clock
  acs_clkdiv #(.HALF_DIV(HALF_DIV)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(cv.half_tick),
    .conv_clk(converter_clock)
  );

  // =====================================================================
  // trigger sources
  logic pwm_q, ext_q;
  logic pwm_rise, ext_rise, sw_trig, any_trig, powered;

  assign pwm_rise = pwm_module_trigger && !pwm_q;
  assign ext_rise = external_start_pin && !ext_q;
  assign sw_trig = wr_acc && hit_trig && pwdata[`ACS_SWTRIG_BIT];
  // a trigger before all three power bits are on would convert garbage
  assign powered = pwd_q && (&bgr_q);
  assign any_trig = (pwm_rise || ext_rise || sw_trig) && powered;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      pwm_q <= pwm_module_trigger;
      ext_q <= external_start_pin;
    end
  end

  // =====================================================================
  // sample/hold sequencer, counted in half converter clocks
  acs_pkg::acs_state_t st_q, st_d;
  logic [`ACS_CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] left_q, left_d;
  logic [3:0] chan_q, chan_d;
  logic run_dual_q, run_dual_d;
  logic [`ACS_CNT_W-1:0] sh_half, gap_half;
  logic cnt_zero, sh_fall, run_end;

  assign sh_half = {acqps_q, 1'b0} + `ACS_CNT_W'(2);
  assign gap_half = run_dual_q ? `ACS_GAP_SIM_HALF : `ACS_GAP_SEQ_HALF;
  assign cnt_zero = (cnt_q == '0);
  assign sh_fall = (st_q == acs_pkg::ACS_SAMPLE) && cv.half_tick && cnt_zero;
  assign run_end = sh_fall && (left_q == 4'h0);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    left_d = left_q;
    chan_d = chan_q;
    run_dual_d = run_dual_q;
    unique case (st_q)
      acs_pkg::ACS_IDLE: begin
        if (any_trig) begin
          st_d = acs_pkg::ACS_DELAY;
          cnt_d = `ACS_TRIG_DLY_HALF - `ACS_CNT_W'(1);
          left_d = num_q;
          run_dual_d = dual_sample_select_q;
          // paired mode forces a matched pair: A index and B index share low bits
          chan_d = dual_sample_select_q ? {1'b0, chsel_q[`ACS_PAIR_MSB:0]} : chsel_q;
        end
      end
      acs_pkg::ACS_DELAY: begin
        if (cv.half_tick) begin
          cnt_d = cnt_q - `ACS_CNT_W'(1);
          if (cnt_zero) begin
            st_d = acs_pkg::ACS_SAMPLE;
            cnt_d = sh_half - `ACS_CNT_W'(1);
          end
        end
      end
      acs_pkg::ACS_SAMPLE: begin
        // new triggers are not looked at here, so a pulse is never cut short
        if (cv.half_tick) begin
          cnt_d = cnt_q - `ACS_CNT_W'(1);
          if (cnt_zero) begin
            if (left_q == 4'h0) begin
              st_d = acs_pkg::ACS_IDLE;
            end else begin
              st_d = acs_pkg::ACS_GAP;
              cnt_d = gap_half - `ACS_CNT_W'(1);
              left_d = left_q - 4'h1;
              chan_d = run_dual_q ? chan_q : chan_q + 4'h1;
            end
          end
        end
      end
      acs_pkg::ACS_GAP: begin
        if (cv.half_tick) begin
          cnt_d = cnt_q - `ACS_CNT_W'(1);
          if (cnt_zero) begin
            st_d = acs_pkg::ACS_SAMPLE;
            cnt_d = sh_half - `ACS_CNT_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= acs_pkg::ACS_IDLE;
      cnt_q <= '0;
      left_q <= 4'h0;
      chan_q <= 4'h0;
      run_dual_q <= 1'b0;
    end else if (srst_q) begin
      st_q <= acs_pkg::ACS_IDLE;
      cnt_q <= '0;
      left_q <= 4'h0;
      chan_q <= 4'h0;
      run_dual_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      chan_q <= chan_d;
      run_dual_q <= run_dual_d;
    end
  end

  assign sh_pulse = (st_q == acs_pkg::ACS_SAMPLE);
  assign sh_chan_a = chan_q;
  assign sh_chan_b = run_dual_q ? {1'b1, chan_q[`ACS_PAIR_MSB:0]} : chan_q;

  // =====================================================================
  // hand-off to the result pipeline
  assign cv.blk_rst = srst_q;
  assign cv.capture = sh_fall;
  assign cv.dual = run_dual_q;
  assign cv.smp_a = ain_a;
  assign cv.smp_b = ain_b;

  acs_pipe u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .cv(cv)
  );

  // =====================================================================
  // result flags trail the result update, and the done flag the run's last sample fall, by a few system clocks
  logic [FLAG_DLY-1:0] fa_q, fb_q, fd_q;
  logic [`ACS_ST_W-1:0] set_ev, clr_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_q <= '0;
      fb_q <= '0;
      fd_q <= '0;
    end else if (srst_q) begin
      fa_q <= '0;
      fb_q <= '0;
      fd_q <= '0;
    end else begin
      fa_q <= {fa_q[FLAG_DLY-2:0], cv.res_a_wr};
      fb_q <= {fb_q[FLAG_DLY-2:0], cv.res_b_wr};
      fd_q <= {fd_q[FLAG_DLY-2:0], run_end};
    end
  end

  assign set_ev = {fd_q[FLAG_DLY-1], fb_q[FLAG_DLY-1], fa_q[FLAG_DLY-1]};
  assign clr_ev = (wr_acc && hit_stat) ? pwdata[`ACS_ST_W-1:0] : '0;

  // set wins over a write-one-to-clear in the same cycle
  always_comb begin
    stat_d = (stat_q & ~clr_ev) | set_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_q <= '0;
    else if (srst_q) stat_q <= '0;
    else stat_q <= stat_d;
  end

  assign irq = |(stat_q & mask_q);
endmodule : acs_top

// *** testbench/acs_src_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// analog inputs and start sources
module acs_src_model (
  input wire logic pclk,
  input wire logic sh_pulse,
  input wire logic [3:0] sh_chan_a,
  input wire logic [3:0] sh_chan_b,
  input wire logic [7:0] salt,
  input wire logic pwm_req,
  input wire logic ext_req,
  output logic pwm_module_trigger,
  output logic external_start_pin,
  output logic [11:0] ain_a,
  output logic [11:0] ain_b
);
  logic [11:0] noise_q = 12'h5a3;
  logic pwm_q = 1'b0;
  logic ext_q = 1'b0;
  // outside the hold window the inputs flip every cycle, so a mistimed capture reads garbage
  always @(posedge pclk) begin
    noise_q <= ~noise_q;
    pwm_q <= pwm_req;
    ext_q <= ext_req;
  end
  assign pwm_module_trigger = pwm_q;
  assign external_start_pin = ext_q;
  assign ain_a = sh_pulse ? {sh_chan_a, salt} : noise_q;
  assign ain_b = sh_pulse ? {sh_chan_b, salt} : ~noise_q;
endmodule : acs_src_model

// *** testbench/acs_top_properties.sv ***
`timescale 1ns/1ps
`include "acs_params.svh"
// =====================================================================
// pin-level timing checks, with shadows of what software wrote
module acs_top_properties #(
  parameter int HALF_DIV = `ACS_HALF_DIV,
  parameter int FLAG_DLY = `ACS_FLAG_DLY
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [`ACS_ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic converter_clock,
  input logic sh_pulse,
  input logic [3:0] sh_chan_a,
  input logic [3:0] sh_chan_b,
  input logic dual_sample_select,
  input logic [1:0] bandgap_ref_power_bits,
  input logic core_power_up_bit,
  input logic irq
);
  localparam int UNIT = 2 * HALF_DIV;
  localparam int LA_LO = 8 * HALF_DIV + FLAG_DLY;
  localparam int LA_HI = LA_LO + 2;
  localparam int LB_LO = 10 * HALF_DIV + FLAG_DLY;
  localparam int LB_HI = LB_LO + 2;
  logic [3:0] acq_q;
  logic [3:0] last_q;
  logic [2:0] mask_q;
  logic [9:0] hi_q;
  logic [9:0] lo_q;
  logic [9:0] cc_q;
  logic fresh_q;
  logic wr_hit;
  logic [3:0] ctrl3_wd;
  assign wr_hit = psel && penable && pwrite && pready;
  assign ctrl3_wd = {pwdata[7:5], pwdata[0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_q <= 4'h0;
      mask_q <= 3'h0;
    end else if (wr_hit && paddr == `ACS_OFF_CTRL1) begin
      acq_q <= pwdata[11:8];
    end else if (wr_hit && paddr == `ACS_OFF_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end
  // saturating, so a long idle never wraps into a false gap match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 10'h000;
      lo_q <= 10'h3ff;
      last_q <= 4'h0;
      fresh_q <= 1'b0;
      cc_q <= 10'h000;
    end else begin
      // only a run's first pulse may arm the flag checks: with a short acquisition, later falls can come before irq rises
      fresh_q <= (sh_pulse && hi_q == 10'h000) ? (lo_q > 10'(3 * UNIT)) : fresh_q;
      cc_q <= $changed(converter_clock) ? 10'h001 : cc_q + 10'h001;
      hi_q <= sh_pulse ? hi_q + 10'h001 : 10'h000;
      lo_q <= sh_pulse ? 10'h000 : lo_q + 10'(lo_q != 10'h3ff);
      last_q <= sh_pulse ? sh_chan_a : last_q;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pulse_width: assert property ($fell(sh_pulse) |-> hi_q == 10'(UNIT * (acq_q + 1)))
    else $error("sample pulse width wrong");
  a_pulse_gap: assert property ($rose(sh_pulse) |->
    lo_q == 10'(dual_sample_select ? 2 * UNIT : UNIT) || lo_q > 10'(3 * UNIT)) else $error("pulse gap wrong");
  a_chan_step: assert property ($rose(sh_pulse) && !dual_sample_select && lo_q == 10'(UNIT) |->
    sh_chan_a == last_q + 4'h1) else $error("channel did not advance");
  a_pair_match: assert property (sh_pulse && dual_sample_select |->
    !sh_chan_a[3] && sh_chan_b == {1'b1, sh_chan_a[2:0]}) else $error("pair mismatch");
  a_power_gate: assert property ($rose(sh_pulse) |-> core_power_up_bit && &bandgap_ref_power_bits)
    else $error("sampling while unpowered");
  a_result_a: assert property ($fell(sh_pulse) && fresh_q && !irq && mask_q == 3'h1 |->
    ##[LA_LO:LA_HI] $rose(irq)) else $error("first result flag late or early");
  a_result_b: assert property ($fell(sh_pulse) && fresh_q && dual_sample_select && !irq && mask_q == 3'h2 |->
    ##[LB_LO:LB_HI] $rose(irq)) else $error("second result flag late or early");
  a_mask_quiet: assert property (wr_hit && paddr == `ACS_OFF_MASK && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq with all masked");
  a_ctrl3_pins: assert property (wr_hit && paddr == `ACS_OFF_CTRL3 |=>
    {bandgap_ref_power_bits, core_power_up_bit, dual_sample_select} == $past(ctrl3_wd))
    else $error("power or mode pins wrong");
  a_conv_clock: assert property ($changed(converter_clock) |-> cc_q == 10'(HALF_DIV))
    else $error("converter clock half period wrong");
endmodule : acs_top_properties

bind acs_top acs_top_properties #(.HALF_DIV(HALF_DIV), .FLAG_DLY(FLAG_DLY)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .converter_clock(converter_clock), .sh_pulse(sh_pulse), .sh_chan_a(sh_chan_a),
  .sh_chan_b(sh_chan_b),
  .dual_sample_select(dual_sample_select), .bandgap_ref_power_bits(bandgap_ref_power_bits),
  .core_power_up_bit(core_power_up_bit), .irq(irq));

// *** testbench/adc_power_sample_sequencer_test.sv ***
`timescale 1ns/1ps
`include "acs_params.svh"
// =====================================================================
// bench: apb driver notes expectations, monitor compares reads
module adc_power_sample_sequencer_test;
  localparam int H = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ACS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pwm_t, ext_t, sh, sh_d, core, irq;
  logic pwm_req = 1'b0;
  logic ext_req = 1'b0;
  logic [7:0] salt = 8'h00;
  logic [11:0] ain_a, ain_b;
  logic [3:0] ch_a, ch_b;
  logic [1:0] bgr;
  logic [32:0] exp_q[$];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int rises = 0;
  always #2 pclk = ~pclk;
  acs_top #(.HALF_DIV(H), .FLAG_DLY(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_module_trigger(pwm_t), .external_start_pin(ext_t), .ain_a(ain_a), .ain_b(ain_b),
    .converter_clock(), .sh_pulse(sh), .sh_chan_a(ch_a), .sh_chan_b(ch_b), .dual_sample_select(),
    .bandgap_ref_power_bits(bgr), .core_power_up_bit(core), .irq(irq));
  acs_src_model src_u (.pclk(pclk), .sh_pulse(sh), .sh_chan_a(ch_a), .sh_chan_b(ch_b), .salt(salt),
    .pwm_req(pwm_req), .ext_req(ext_req), .pwm_module_trigger(pwm_t), .external_start_pin(ext_t),
    .ain_a(ain_a), .ain_b(ain_b));
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_sh(input logic lvl);
    for (int i = 0; i < 400 && sh !== lvl; i++) @(posedge pclk);
  endtask : wait_sh
  // src: 0 software, 1 pwm, 2 external pin
  task automatic run(input logic [3:0] acq, input logic [3:0] num, input logic [3:0] ch, input logic dm,
                     input int src);
    logic [3:0] last;
    last = dm ? {1'b0, ch[2:0]} : ch + num;
    salt <= 8'($urandom);
    apb(1'b1, `ACS_OFF_CTRL3, 32'he0 | 32'(dm), '0);
    apb(1'b1, `ACS_OFF_CTRL1, 32'({acq, 4'h0, num}), '0);
    apb(1'b1, `ACS_OFF_CHSEL, 32'(ch), '0);
    apb(1'b1, `ACS_OFF_STAT, 32'h7, '0);
    apb(1'b1, `ACS_OFF_MASK, dm ? 32'h2 : 32'h1, '0);
    rises = 0;
    if (src == 0) apb(1'b1, `ACS_OFF_TRIG, 32'h1, '0);
    else if (src == 1) pwm_req <= 1'b1;
    else ext_req <= 1'b1;
    wait_sh(1'b1);
    pwm_req <= 1'b0;
    ext_req <= 1'b0;
    @(posedge pclk);
    pwm_req <= 1'b1;
    ext_req <= 1'b1;
    @(posedge pclk);
    pwm_req <= 1'b0;
    ext_req <= 1'b0;
    repeat (40 + (32'(num) + 1) * (2 * 32'(acq) + 6) * H) @(posedge pclk);
    check(33'(rises), 33'(num) + 33'h1);
    check({32'h0, irq}, 33'h1);
    apb(1'b0, `ACS_OFF_RESA, '0, 33'({last, salt}));
    if (dm) apb(1'b0, `ACS_OFF_RESB, '0, 33'({1'b1, ch[2:0], salt}));
    apb(1'b0, `ACS_OFF_STAT, '0, dm ? 33'h7 : 33'h5);
    apb(1'b1, `ACS_OFF_MASK, 32'h0, '0);
    check({32'h0, irq}, 33'h0);
    $display("conversion run done, dual=%0d src=%0d", dm, src);
  endtask : run
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    sh_d <= sh;
    if (sh && !sh_d) rises++;
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(36602));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ACS_OFF_CTRL3, '0, 33'h0);
    apb(1'b0, `ACS_OFF_STAT, '0, 33'h0);
    apb(1'b0, 8'h20, '0, 33'h1_0000_0000);
    rises = 0;
    apb(1'b1, `ACS_OFF_TRIG, 32'h1, '0);
    repeat (40) @(posedge pclk);
    check(33'(rises), 33'h0);
    // settling waits are scaled down: the block does not time them itself
    apb(1'b1, `ACS_OFF_CTRL3, 32'hc0, '0);
    repeat (50) @(posedge pclk);
    check({30'h0, bgr, core}, 33'h6);
    apb(1'b1, `ACS_OFF_CTRL3, 32'he0, '0);
    check({30'h0, bgr, core}, 33'h7);
    $display("power-up test done");
    run(4'($urandom), 4'h3, 4'($urandom), 1'b0, 0);
    run(4'hf, 4'h0, 4'hf, 1'b0, 2);
    apb(1'b1, `ACS_OFF_CTRL3, 32'h0, '0);
    run(4'h0, 4'h2, 4'($urandom % 8), 1'b1, 1);
    apb(1'b1, `ACS_OFF_CTRL1, 32'h000f, '0);
    apb(1'b1, `ACS_OFF_TRIG, 32'h1, '0);
    wait_sh(1'b1);
    wait_sh(1'b0);
    apb(1'b1, `ACS_OFF_CTRL1, 32'h400f, '0);
    rises = 0;
    repeat (60) @(posedge pclk);
    check(33'(rises), 33'h0);
    apb(1'b0, `ACS_OFF_STAT, '0, 33'h0);
    apb(1'b0, `ACS_OFF_CTRL3, '0, 33'he1);
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule : adc_power_sample_sequencer_test
